// ==== hdl/rate_cfg_pkg.sv ====
// shared constants and types for the reference rate configuration bank
package rate_cfg_pkg;

  // field widths
  localparam int unsigned RATE_W    = 16;
  localparam int unsigned RATIO_W   = 32;
  localparam int unsigned PRODUCT_W = 48;
  localparam int unsigned NOMINAL_W = 32;
  localparam int unsigned STEP_W    = 6;

  // byte addresses of the first byte of each register
  localparam logic [7:0] FIRST_RATIO_OFS       = 8'h1c;
  localparam logic [7:0] SECOND_BASE_RATE_OFS  = 8'h20;
  localparam logic [7:0] SECOND_RATE_FACTOR_OFS = 8'h22;
  localparam logic [7:0] SECOND_RATIO_OFS      = 8'h24;
  localparam logic [7:0] CALC_STATUS_OFS       = 8'h30;
  localparam logic [7:0] NOMINAL_RATE_OFS      = 8'h34;

  // reset values: 40 kHz times 486 with unity ratio gives 19.44 MHz
  localparam logic [15:0] SECOND_BASE_RATE_RST   = 16'h9c40;
  localparam logic [15:0] SECOND_RATE_FACTOR_RST = 16'h01e6;
  localparam logic [31:0] RATIO_RST              = 32'h00010001;

  // ratio field positions
  localparam int unsigned NUMERATOR_LSB   = 16;
  localparam int unsigned DENOMINATOR_LSB = 0;

  // status bit positions
  localparam int unsigned ST_BUSY       = 0;
  localparam int unsigned ST_VALID      = 1;
  localparam int unsigned ST_DIV_ZERO   = 2;
  localparam int unsigned ST_OVERFLOW   = 3;
  localparam int unsigned ST_PEND_BASE  = 4;
  localparam int unsigned ST_PEND_MULT  = 5;
  localparam int unsigned ST_PEND_RATIO = 6;
  localparam int unsigned ST_PEND_FIRST = 7;

  // index of the last restoring divide step; 48 steps, one per product bit
  localparam logic [STEP_W-1:0] DIV_LAST_STEP = 6'h2f;

  // one register bus request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } bus_req_s;

  // numerator in the upper half, denominator in the lower half
  typedef struct packed {
    logic [15:0] numerator;
    logic [15:0] denominator;
  } ratio_s;

  // nominal frequency calculator states
  typedef enum logic [1:0] {
    CALC_IDLE = 2'b00,
    CALC_MUL  = 2'b01,
    CALC_DIV  = 2'b10
  } calc_state_e;

endpackage

// ==== hdl/rate_cfg_stage.sv ====
// byte-written register with staging copy and commit on the final byte
`timescale 1ns/10ps
`default_nettype none
module rate_cfg_stage
  import rate_cfg_pkg::*;
#(
  parameter int unsigned             NBYTES    = 2,
  parameter logic [7:0]              BASE      = 8'h00,
  parameter logic [8*NBYTES-1:0]     RESET_VAL = '0
)(
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire bus_req_s              req,
  output logic [8*NBYTES-1:0]        staged,
  output logic [8*NBYTES-1:0]        active,
  output logic                       pending,
  output logic                       commit
);

  logic [NBYTES-1:0]     hit;
  logic [8*NBYTES-1:0]   next_staged;
  logic [8*NBYTES-1:0]   next_active;
  logic                  next_pending;
  logic                  next_commit;

  // byte at BASE+i is the i-th most significant byte
  genvar gi;
  generate
    for (gi = 0; gi < NBYTES; gi++) begin : g_hit
      assign hit[gi] = req.wr && (req.addr == 8'(BASE + gi));
    end
  endgenerate

  // merge written byte, commit only when the last byte lands
  always_comb begin
    next_staged  = staged;
    next_active  = active;
    next_pending = pending;
    next_commit  = 1'b0;
    for (int i = 0; i < NBYTES; i++) begin
      if (hit[i]) begin
        next_staged[8*(NBYTES-1-i) +: 8] = req.wdata;
      end
    end
    if (hit[NBYTES-1]) begin
      next_active  = next_staged;
      next_pending = 1'b0;
      next_commit  = 1'b1;
    end else if (|hit) begin
      next_pending = 1'b1;
    end
  end

  // state registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      staged  <= RESET_VAL;
      active  <= RESET_VAL;
      pending <= 1'b0;
      commit  <= 1'b0;
    end else begin
      staged  <= next_staged;
      active  <= next_active;
      pending <= next_pending;
      commit  <= next_commit;
    end
  end

endmodule
`default_nettype wire

// ==== hdl/reference_rate_config_bank.sv ====
// reference rate configuration bank with nominal frequency calculator
//
// The address-and-strobe port was decided locally.
`timescale 1ns/10ps
`default_nettype none
module reference_rate_config_bank
  import rate_cfg_pkg::*;
(
  input  wire logic                  CLK,
  input  wire logic                  RST_N,
  input  wire logic [7:0]            ADDR,
  input  wire logic [7:0]            WDATA,
  input  wire logic                  WR_STB,
  input  wire logic                  RD_STB,
  output logic [7:0]                 RDATA,
  output logic [RATE_W-1:0]          SECOND_BASE_RATE_HZ,
  output logic [RATE_W-1:0]          SECOND_BASE_MULTIPLE,
  output logic [RATE_W-1:0]          SECOND_CORRECTION_NUMERATOR,
  output logic [RATE_W-1:0]          SECOND_CORRECTION_DENOMINATOR,
  output logic [RATE_W-1:0]          FIRST_CORRECTION_NUMERATOR,
  output logic [RATE_W-1:0]          FIRST_CORRECTION_DENOMINATOR,
  output logic [PRODUCT_W-1:0]       SECOND_NOMINAL_HZ,
  output logic                       NOMINAL_VALID,
  output logic                       CONFIG_UPDATE
);

  bus_req_s              req;
  logic [RATE_W-1:0]     base_staged;
  logic [RATE_W-1:0]     base_active;
  logic [RATE_W-1:0]     mult_staged;
  logic [RATE_W-1:0]     mult_active;
  logic [RATIO_W-1:0]    ratio_staged;
  logic [RATIO_W-1:0]    ratio_active;
  logic [RATIO_W-1:0]    first_staged;
  logic [RATIO_W-1:0]    first_active;
  logic                  base_pend;
  logic                  mult_pend;
  logic                  ratio_pend;
  logic                  first_pend;
  logic                  base_commit;
  logic                  mult_commit;
  logic                  ratio_commit;
  logic                  first_commit;
  ratio_s                second_ratio;
  ratio_s                first_ratio;
  logic                  restart;

  // bus request carried as one bundle
  assign req = '{addr: ADDR, wdata: WDATA, wr: WR_STB, rd: RD_STB};

  // second input base rate in hertz
  rate_cfg_stage #(
    .NBYTES    (2),
    .BASE      (SECOND_BASE_RATE_OFS),
    .RESET_VAL (SECOND_BASE_RATE_RST)
  ) u_base_rate (
    .clk     (CLK),
    .rst_n   (RST_N),
    .req     (req),
    .staged  (base_staged),
    .active  (base_active),
    .pending (base_pend),
    .commit  (base_commit)
  );

  // second input base multiple
  rate_cfg_stage #(
    .NBYTES    (2),
    .BASE      (SECOND_RATE_FACTOR_OFS),
    .RESET_VAL (SECOND_RATE_FACTOR_RST)
  ) u_rate_factor (
    .clk     (CLK),
    .rst_n   (RST_N),
    .req     (req),
    .staged  (mult_staged),
    .active  (mult_active),
    .pending (mult_pend),
    .commit  (mult_commit)
  );

  // second input correction ratio
  rate_cfg_stage #(
    .NBYTES    (4),
    .BASE      (SECOND_RATIO_OFS),
    .RESET_VAL (RATIO_RST)
  ) u_second_ratio (
    .clk     (CLK),
    .rst_n   (RST_N),
    .req     (req),
    .staged  (ratio_staged),
    .active  (ratio_active),
    .pending (ratio_pend),
    .commit  (ratio_commit)
  );

  // first input correction ratio, same field layout
  rate_cfg_stage #(
    .NBYTES    (4),
    .BASE      (FIRST_RATIO_OFS),
    .RESET_VAL (RATIO_RST)
  ) u_first_ratio (
    .clk     (CLK),
    .rst_n   (RST_N),
    .req     (req),
    .staged  (first_staged),
    .active  (first_active),
    .pending (first_pend),
    .commit  (first_commit)
  );

  // split committed ratios into numerator and denominator
  assign second_ratio = ratio_s'(ratio_active);
  assign first_ratio  = ratio_s'(first_active);

  // committed values toward the pll
  assign SECOND_BASE_RATE_HZ           = base_active;
  assign SECOND_BASE_MULTIPLE          = mult_active;
  assign SECOND_CORRECTION_NUMERATOR   = second_ratio.numerator;
  assign SECOND_CORRECTION_DENOMINATOR = second_ratio.denominator;
  assign FIRST_CORRECTION_NUMERATOR    = first_ratio.numerator;
  assign FIRST_CORRECTION_DENOMINATOR  = first_ratio.denominator;

  // any commit on the second input restarts the calculation
  assign restart = base_commit | mult_commit | ratio_commit;

  // ------------------------------------------------------------------
  // nominal frequency calculator: one multiply cycle, then restoring
  // division one bit per cycle; a zero denominator is flagged
  // ------------------------------------------------------------------
  calc_state_e           state;
  calc_state_e           next_state;
  logic [PRODUCT_W-1:0]  quo;
  logic [PRODUCT_W-1:0]  next_quo;
  logic [RATE_W:0]       rem;
  logic [RATE_W:0]       next_rem;
  logic [RATE_W:0]       rem_sh;
  logic [RATE_W:0]       den_ext;
  logic [STEP_W-1:0]     step;
  logic [STEP_W-1:0]     next_step;
  logic                  valid;
  logic                  next_valid;
  logic                  div_zero;
  logic                  next_div_zero;
  logic                  overflow;
  logic                  next_overflow;
  logic [PRODUCT_W-1:0]  nominal;
  logic [PRODUCT_W-1:0]  next_nominal;
  logic [PRODUCT_W-1:0]  step_quo;
  logic [RATE_W:0]       step_rem;
  logic                  next_update;
  logic                  update;

  // one restoring divide step on the current remainder and dividend
  always_comb begin
    den_ext = {1'b0, second_ratio.denominator};
    rem_sh  = {rem[RATE_W-1:0], quo[PRODUCT_W-1]};
    if (rem_sh >= den_ext) begin
      step_rem = rem_sh - den_ext;
      step_quo = {quo[PRODUCT_W-2:0], 1'b1};
    end else begin
      step_rem = rem_sh;
      step_quo = {quo[PRODUCT_W-2:0], 1'b0};
    end
  end

  // calculator next values
  always_comb begin
    next_state    = state;
    next_quo      = quo;
    next_rem      = rem;
    next_step     = step;
    next_valid    = valid;
    next_div_zero = div_zero;
    next_overflow = overflow;
    next_nominal  = nominal;
    if (restart) begin
      next_state = CALC_MUL;
      next_valid = 1'b0;
    end else begin
      unique case (state)
        CALC_IDLE: begin
          next_state = CALC_IDLE;
        end
        CALC_MUL: begin
          next_quo  = PRODUCT_W'(base_active) * PRODUCT_W'(mult_active)
                    * PRODUCT_W'(second_ratio.numerator);
          next_rem  = '0;
          next_step = DIV_LAST_STEP;
          if (second_ratio.denominator == 16'h0000) begin
            next_div_zero = 1'b1;
            next_valid    = 1'b0;
            next_state    = CALC_IDLE;
          end else begin
            next_div_zero = 1'b0;
            next_state    = CALC_DIV;
          end
        end
        CALC_DIV: begin
          next_quo = step_quo;
          next_rem = step_rem;
          if (step == '0) begin
            next_nominal  = step_quo;
            next_overflow = |step_quo[PRODUCT_W-1:NOMINAL_W];
            next_valid    = 1'b1;
            next_state    = CALC_IDLE;
          end else begin
            next_step = step - 6'h01;
          end
        end
        default: begin
          next_state = CALC_IDLE;
        end
      endcase
    end
  end

  // calculator registers; reset starts a calculation of the defaults
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      state    <= CALC_MUL;
      quo      <= '0;
      rem      <= '0;
      step     <= '0;
      valid    <= 1'b0;
      div_zero <= 1'b0;
      overflow <= 1'b0;
      nominal  <= '0;
    end else begin
      state    <= next_state;
      quo      <= next_quo;
      rem      <= next_rem;
      step     <= next_step;
      valid    <= next_valid;
      div_zero <= next_div_zero;
      overflow <= next_overflow;
      nominal  <= next_nominal;
    end
  end

  assign SECOND_NOMINAL_HZ = nominal;
  assign NOMINAL_VALID     = valid;

  // one-cycle notice that some committed value changed
  assign next_update = restart | first_commit;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      update <= 1'b0;
    end else begin
      update <= next_update;
    end
  end

  assign CONFIG_UPDATE = update;

  // ------------------------------------------------------------------
  // read side: data stands only in the cycle after the read strobe
  // ------------------------------------------------------------------
  logic [7:0]  status;
  logic [7:0]  rd_byte;
  logic [7:0]  next_rdata;

  // calculator and staging state for software
  always_comb begin
    status                = 8'h00;
    status[ST_BUSY]       = (state != CALC_IDLE);
    status[ST_VALID]      = valid;
    status[ST_DIV_ZERO]   = div_zero;
    status[ST_OVERFLOW]   = overflow;
    status[ST_PEND_BASE]  = base_pend;
    status[ST_PEND_MULT]  = mult_pend;
    status[ST_PEND_RATIO] = ratio_pend;
    status[ST_PEND_FIRST] = first_pend;
  end

  // byte select, most significant byte at the lowest address
  always_comb begin
    unique case (ADDR)
      FIRST_RATIO_OFS:                 rd_byte = first_staged[31:24];
      8'(FIRST_RATIO_OFS + 8'h01):     rd_byte = first_staged[23:16];
      8'(FIRST_RATIO_OFS + 8'h02):     rd_byte = first_staged[15:8];
      8'(FIRST_RATIO_OFS + 8'h03):     rd_byte = first_staged[7:0];
      SECOND_BASE_RATE_OFS:            rd_byte = base_staged[15:8];
      8'(SECOND_BASE_RATE_OFS + 8'h01): rd_byte = base_staged[7:0];
      SECOND_RATE_FACTOR_OFS:          rd_byte = mult_staged[15:8];
      8'(SECOND_RATE_FACTOR_OFS + 8'h01): rd_byte = mult_staged[7:0];
      SECOND_RATIO_OFS:                rd_byte = ratio_staged[31:24];
      8'(SECOND_RATIO_OFS + 8'h01):    rd_byte = ratio_staged[23:16];
      8'(SECOND_RATIO_OFS + 8'h02):    rd_byte = ratio_staged[15:8];
      8'(SECOND_RATIO_OFS + 8'h03):    rd_byte = ratio_staged[7:0];
      CALC_STATUS_OFS:                 rd_byte = status;
      NOMINAL_RATE_OFS:                rd_byte = nominal[31:24];
      8'(NOMINAL_RATE_OFS + 8'h01):    rd_byte = nominal[23:16];
      8'(NOMINAL_RATE_OFS + 8'h02):    rd_byte = nominal[15:8];
      8'(NOMINAL_RATE_OFS + 8'h03):    rd_byte = nominal[7:0];
      default:                         rd_byte = 8'h00;
    endcase
  end

  assign next_rdata = RD_STB ? rd_byte : 8'h00;

  // read data register
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      RDATA <= 8'h00;
    end else begin
      RDATA <= next_rdata;
    end
  end

endmodule
`default_nettype wire

// ==== dv/rate_bank_sva.sv ====
// concurrent checks on the reference rate configuration bank ports
`timescale 1ns/10ps
`default_nettype none
module rate_bank_sva
  import rate_cfg_pkg::*;
(
  input wire logic                 CLK,
  input wire logic                 RST_N,
  input wire logic [7:0]           ADDR,
  input wire logic                 WR_STB,
  input wire logic                 RD_STB,
  input wire logic [7:0]           RDATA,
  input wire logic [RATE_W-1:0]    SECOND_BASE_RATE_HZ,
  input wire logic [RATE_W-1:0]    SECOND_BASE_MULTIPLE,
  input wire logic [RATE_W-1:0]    SECOND_CORRECTION_NUMERATOR,
  input wire logic [RATE_W-1:0]    SECOND_CORRECTION_DENOMINATOR,
  input wire logic [RATE_W-1:0]    FIRST_CORRECTION_NUMERATOR,
  input wire logic [RATE_W-1:0]    FIRST_CORRECTION_DENOMINATOR,
  input wire logic [PRODUCT_W-1:0] SECOND_NOMINAL_HZ,
  input wire logic                 NOMINAL_VALID,
  input wire logic                 CONFIG_UPDATE
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  // final-byte writes that commit each register
  logic wr_base_end;
  logic wr_mult_end;
  logic wr_ratio_end;
  logic wr_first_end;
  assign wr_base_end  = WR_STB && ADDR == 8'h21;
  assign wr_mult_end  = WR_STB && ADDR == 8'h23;
  assign wr_ratio_end = WR_STB && ADDR == 8'h27;
  assign wr_first_end = WR_STB && ADDR == 8'h1f;

  property p_rdata_idle;
    !RD_STB |=> RDATA == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");
  property p_base_hold;
    $changed(SECOND_BASE_RATE_HZ) |-> $past(wr_base_end) || $past(wr_base_end, 2);
  endproperty
  a_base_hold: assert property (p_base_hold) else $error("base rate moved early");
  property p_mult_hold;
    $changed(SECOND_BASE_MULTIPLE) |-> $past(wr_mult_end) || $past(wr_mult_end, 2);
  endproperty
  a_mult_hold: assert property (p_mult_hold) else $error("multiple moved early");
  property p_ratio_hold;
    $changed({SECOND_CORRECTION_NUMERATOR, SECOND_CORRECTION_DENOMINATOR})
      |-> $past(wr_ratio_end) || $past(wr_ratio_end, 2);
  endproperty
  a_ratio_hold: assert property (p_ratio_hold) else $error("ratio moved early");
  property p_first_hold;
    $changed({FIRST_CORRECTION_NUMERATOR, FIRST_CORRECTION_DENOMINATOR})
      |-> $past(wr_first_end) || $past(wr_first_end, 2);
  endproperty
  a_first_hold: assert property (p_first_hold) else $error("first ratio moved early");
  property p_update;
    wr_base_end || wr_mult_end || wr_ratio_end || wr_first_end |-> ##[1:3] CONFIG_UPDATE;
  endproperty
  a_update: assert property (p_update) else $error("no update pulse");
  property p_nominal_stable;
    NOMINAL_VALID && $past(NOMINAL_VALID) |-> $stable(SECOND_NOMINAL_HZ);
  endproperty
  a_nominal_stable: assert property (p_nominal_stable) else $error("nominal moved");
  // a zero denominator committed now must leave the result invalid from the next cycle on
  property p_den_nonzero;
    SECOND_CORRECTION_DENOMINATOR == 16'h0000 |=> !NOMINAL_VALID;
  endproperty
  a_den_nonzero: assert property (p_den_nonzero) else $error("valid with zero den");
  // unity ratio: nominal is base times multiple
  property p_unity;
    NOMINAL_VALID && $stable(SECOND_BASE_RATE_HZ) && $stable(SECOND_BASE_MULTIPLE)
      && $stable({SECOND_CORRECTION_NUMERATOR, SECOND_CORRECTION_DENOMINATOR})
      && SECOND_CORRECTION_NUMERATOR == SECOND_CORRECTION_DENOMINATOR
      |-> SECOND_NOMINAL_HZ == PRODUCT_W'(SECOND_BASE_RATE_HZ) * PRODUCT_W'(SECOND_BASE_MULTIPLE);
  endproperty
  a_unity: assert property (p_unity) else $error("unity nominal wrong");
endmodule

bind reference_rate_config_bank rate_bank_sva u_rate_bank_sva (
  .CLK(CLK), .RST_N(RST_N), .ADDR(ADDR), .WR_STB(WR_STB), .RD_STB(RD_STB), .RDATA(RDATA),
  .SECOND_BASE_RATE_HZ(SECOND_BASE_RATE_HZ), .SECOND_BASE_MULTIPLE(SECOND_BASE_MULTIPLE),
  .SECOND_CORRECTION_NUMERATOR(SECOND_CORRECTION_NUMERATOR),
  .SECOND_CORRECTION_DENOMINATOR(SECOND_CORRECTION_DENOMINATOR),
  .FIRST_CORRECTION_NUMERATOR(FIRST_CORRECTION_NUMERATOR),
  .FIRST_CORRECTION_DENOMINATOR(FIRST_CORRECTION_DENOMINATOR),
  .SECOND_NOMINAL_HZ(SECOND_NOMINAL_HZ), .NOMINAL_VALID(NOMINAL_VALID),
  .CONFIG_UPDATE(CONFIG_UPDATE));
`default_nettype wire

// ==== dv/rate_host_model.sv ====
// host software model driving the byte-wide register port
`timescale 1ns/10ps
`default_nettype none
module rate_host_model (
  input  wire logic       clk,
  output logic [7:0]      addr,
  output logic [7:0]      wdata,
  output logic            wr_stb,
  output logic            rd_stb,
  input  wire logic [7:0] rdata
);
  // idle bus at time zero
  initial begin
    addr   = 8'h00;
    wdata  = 8'h00;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
  end

  // released bus: strobes low, address and data scrambled
  task automatic release_bus();
    wr_stb <= 1'b0;
    rd_stb <= 1'b0;
    addr   <= ~addr;
    wdata  <= ~wdata;
    @(posedge clk);
  endtask

  // one byte write, held until the taking edge
  task automatic put(input logic [7:0] a, input logic [7:0] d);
    addr   <= a;
    wdata  <= d;
    wr_stb <= 1'b1;
    @(posedge clk);
  endtask

  // wide writes go most significant byte first, at the lower address
  task automatic wr16(input logic [7:0] a, input logic [15:0] v);
    put(a, v[15:8]);
    put(a + 8'h01, v[7:0]);
    release_bus();
  endtask

  task automatic wr32(input logic [7:0] a, input logic [31:0] v);
    wr16(a, v[31:16]);
    wr16(a + 8'h02, v[15:0]);
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    addr   <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    addr   <= ~a;
    #2 d = rdata;
    @(posedge clk);
  endtask
endmodule
`default_nettype wire

// ==== dv/reference_rate_config_bank_bench.sv ====
// self-checking bench for the reference rate configuration bank
`timescale 1ns/10ps
`default_nettype none
module reference_rate_config_bank_bench import rate_cfg_pkg::*;;
  logic        clk, rst_n, wr_stb, rd_stb, valid, update;
  logic [7:0]  addr, wdata, rdata, b;
  logic [15:0] base, mult, num, den, fnum, fden, nb, nm, nn, nd;
  logic [31:0] old_ratio, v;
  logic [47:0] nominal, exp_nom;
  logic [63:0] rst_img;
  integer      seed;
  int          err_total, checks_done, n;
  logic [63:0] corner [3] = '{64'h9c40_0f30_00ff_00ed, 64'h61a8_186a_41be_3b80,
                              64'hffff_ffff_ffff_0001};
  logic [15:0] rates [9] = '{16'h03e8, 16'h07d0, 16'h1388, 16'h186a, 16'h1f40,
                             16'h2710, 16'h30d4, 16'h61a8, 16'h9c40};

  reference_rate_config_bank u_reference_rate_config_bank (
    .CLK(clk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR_STB(wr_stb),
    .RD_STB(rd_stb), .RDATA(rdata), .SECOND_BASE_RATE_HZ(base),
    .SECOND_BASE_MULTIPLE(mult), .SECOND_CORRECTION_NUMERATOR(num),
    .SECOND_CORRECTION_DENOMINATOR(den), .FIRST_CORRECTION_NUMERATOR(fnum),
    .FIRST_CORRECTION_DENOMINATOR(fden), .SECOND_NOMINAL_HZ(nominal),
    .NOMINAL_VALID(valid), .CONFIG_UPDATE(update));

  rate_host_model u_rate_host_model (
    .clk(clk), .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
    .rdata(rdata));

  // 8 ns clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // expected nominal: floor of base times multiple times num over den
  function automatic logic [47:0] nominal_of(input logic [15:0] fb, fm, fn, fd);
    logic [63:0] p;
    p = {48'h0, fb} * {48'h0, fm} * {48'h0, fn};
    return 48'(p / {48'h0, fd});
  endfunction

  // expected calculator status byte; busy and pending bits are low when idle
  function automatic logic [7:0] status_of(input logic v, z, o);
    status_of = 8'h00;
    status_of[ST_VALID] = v;
    status_of[ST_DIV_ZERO] = z;
    status_of[ST_OVERFLOW] = o;
  endfunction

  task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  // count edges until the nominal result is valid, bounded
  task automatic wait_valid();
    n = 0;
    do begin
      @(posedge clk);
      #1 n++;
    end while (valid !== 1'b1 && n < 300);
  endtask

  task automatic print_verdict();
    $display("mismatches %0d, comparisons %0d", err_total, checks_done);
    if (err_total == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // watchdog: the run needs about 1100 cycles, allow far more
  initial begin
    #100000;
    err_total++;
    print_verdict();
  end

  // main sequence
  initial begin
    seed = 61;
    err_total = 0;
    checks_done = 0;
    rst_n = 1'b0;
    rst_img = {SECOND_BASE_RATE_RST, SECOND_RATE_FACTOR_RST, RATIO_RST};
    repeat (5) @(posedge clk);
    #1 check({base, mult}, rst_img[63:32], "base/mult rst");
    check({num, den}, RATIO_RST, "ratio rst");
    check({fnum, fden}, RATIO_RST, "first rst");
    @(posedge clk);
    rst_n <= 1'b1;
    wait_valid();
    // one multiply edge, then one edge per divide step
    check(n, int'(DIV_LAST_STEP) + 2, "calc edges");
    check(nominal, 48'h128a180, "rst nominal");
    for (int i = 0; i < 8; i++) begin
      u_rate_host_model.rd(SECOND_BASE_RATE_OFS + 8'(i), b);
      check(b, rst_img[63-8*i -: 8], "rst byte");
    end
    u_rate_host_model.put(8'h11, 8'h5a);
    u_rate_host_model.release_bus();
    u_rate_host_model.rd(8'h11, b);
    check(b, 8'h00, "unmapped");
    old_ratio = RATIO_RST;
    // corner ratios first, then random rates and factors
    for (int k = 0; k < 14; k++) begin
      if (k < 3) begin
        {nb, nm, nn, nd} = corner[k];
      end else begin
        nb = rates[$unsigned($random(seed)) % 9];
        nm = 16'($random(seed));
        nn = (k % 3 == 0) ? 16'h0001 : 16'($random(seed)) | 16'h0001;
        nd = (k % 3 == 0) ? 16'h0001 : 16'($random(seed)) | 16'h0001;
      end
      u_rate_host_model.wr16(SECOND_BASE_RATE_OFS, nb);
      u_rate_host_model.wr16(SECOND_RATE_FACTOR_OFS, nm);
      u_rate_host_model.put(SECOND_RATIO_OFS, nn[15:8]);
      u_rate_host_model.put(SECOND_RATIO_OFS + 8'h01, nn[7:0]);
      u_rate_host_model.put(SECOND_RATIO_OFS + 8'h02, nd[15:8]);
      u_rate_host_model.release_bus();
      #1 check({num, den}, old_ratio, "ratio early");
      u_rate_host_model.put(SECOND_RATIO_OFS + 8'h03, nd[7:0]);
      u_rate_host_model.release_bus();
      #1 check({num, den}, {nn, nd}, "ratio");
      check(base, nb, "base");
      check(mult, nm, "mult");
      wait_valid();
      check(valid, 1'b1, "valid");
      exp_nom = nominal_of(nb, nm, nn, nd);
      check(nominal, exp_nom, "nominal");
      u_rate_host_model.rd(CALC_STATUS_OFS, b);
      check(b, status_of(1'b1, 1'b0, |exp_nom[47:32]), "status");
      u_rate_host_model.rd(NOMINAL_RATE_OFS + 8'h03, b);
      check(b, exp_nom[7:0], "nominal lsb");
      u_rate_host_model.rd(SECOND_BASE_RATE_OFS, b);
      check(b, nb[15:8], "base msb");
      old_ratio = {nn, nd};
    end
    v = $random(seed);
    u_rate_host_model.wr32(FIRST_RATIO_OFS, v);
    #1 check({fnum, fden}, v, "first ratio");
    u_rate_host_model.wr32(SECOND_RATIO_OFS, 32'h0001_0000);
    repeat (60) @(posedge clk);
    #1 check(valid, 1'b0, "zero den");
    u_rate_host_model.rd(CALC_STATUS_OFS, b);
    check(b, status_of(1'b0, 1'b1, |exp_nom[47:32]), "zero den status");
    print_verdict();
  end
endmodule
`default_nettype wire
